// [hcs_status.sv]
// Status register bits 0 to 10 of one serial framing channel, reached over AHB-Lite.
//
// Operation
// - Level status bits follow their underlying condition, set and cleared by hardware.
// - Other status bits except 3 to 0 stay set until software writes one to them.
// - On a complete frame, bits 3 to 0 hold valid final bytes minus one.
// - Remaining bytes span 0 to 3 in one-word mode, 0 to 15 in four-word.
// - Frame complete sets on empty transmit FIFO plus abort or closing flag.
// - One-word mode: transmit FIFO available when its first register is empty.
// - Four-word mode: transmit FIFO available when first four registers are empty.
// - Transmit FIFO available clears when space goes; reads zero during transmit DMA.
// - Bit 6 shows the clear-to-send pin inverted and never interrupts.
// - Bit 7 sets on any clear-to-send pin transition until written with one.
// - Running out of data mid-frame ends the frame with an abort.
// - A transmit underrun sets bit 8 until software writes one.
// - Receive FIFO available means readable data other than address or final word.
// - One-word mode: receive FIFO available when the last register holds data.
// - Four-word mode: receive FIFO available when the last four registers hold data.
// - With the end-of-frame marker set, two words already count as valid.
// - Receive FIFO available clears when data runs out; zero during receive DMA.
// - Frame good sets when a frame has been sent successfully.
// - Reading the status register changes no bit.
`timescale 1ns/1ps
`include "hcs_map.svh"

module hcs_status (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire hcs_pkg::hcs_tx_ev_t tx_ev,
  input  wire hcs_pkg::hcs_rx_ev_t rx_ev,
  input  wire logic              clear_to_send_in_n,
  output logic                   tx_abort_req
);
  import hcs_pkg::*;

  // Address decode shared by the read and the write path.
  function automatic logic hcs_hit(input logic [`HCS_ADDR_W-1:0] a, input logic [`HCS_ADDR_W-1:0] off);
    hcs_hit = (a == off);
  endfunction

  // Final byte count minus one, held to the range of the current transfer mode.
  function automatic logic [3:0] hcs_rb(input logic [4:0] bytes, input logic four);
    logic [4:0] dec;
    logic [3:0] lim;
    dec = (bytes == 5'h00) ? 5'h00 : 5'(bytes - 5'h01);
    lim = four ? `HCS_RB_MAX_FOUR : `HCS_RB_MAX_ONE;
    hcs_rb = (dec > {1'b0, lim}) ? lim : dec[3:0];
  endfunction

  hcs_top_state_t           s;
  hcs_top_state_t           next_s;
  logic                     cts_sync;
  logic                     take;
  logic                     ur_evt;
  logic                     four;
  logic                     dma_tx;
  logic                     dma_rx;
  logic                     stat_wr;
  logic [31:0]              status_word;
  logic [`HCS_STK_NUM-1:0]  stk_set;
  logic [`HCS_STK_NUM-1:0]  stk_clr;
  logic [`HCS_STK_NUM-1:0]  stk_q;

  // The clear-to-send pin is asynchronous to the bus clock.
  hcs_sync u_cts_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       (clear_to_send_in_n),
    .q       (cts_sync)
  );

  // Mode bits from the configuration register steer the availability logic.
  assign four   = s.cfg[`HCS_CFG_FOUR_BIT];
  assign dma_tx = s.cfg[`HCS_CFG_DTX_BIT];
  assign dma_rx = s.cfg[`HCS_CFG_DRX_BIT];

  // A transfer is taken in its address phase only when the bus is ready.
  assign take = hsel & hready & htrans[1];

  // Underrun: the transmitter asks for data inside a frame and the FIFO is dry.
  assign ur_evt = tx_ev.need_data & tx_ev.in_frame & tx_ev.fifo_empty;

  // A data-phase write to the status word clears flags only where a one is written.
  assign stat_wr = s.wr_pend & hcs_hit(s.wr_addr, `HCS_STATUS_OFF);

  // Events that set the sticky flags.
  assign stk_set[`HCS_STK_FC]   = tx_ev.fifo_empty & (tx_ev.abort_sent | tx_ev.flag_sent);
  assign stk_set[`HCS_STK_SCTS] = cts_sync ^ s.cts_prev;
  assign stk_set[`HCS_STK_UR]   = ur_evt;
  assign stk_set[`HCS_STK_FG]   = tx_ev.frame_ok;

  // Only the write-one-to-clear positions are wired to the clear; level bits ignore writes.
  assign stk_clr[`HCS_STK_FC]   = stat_wr & hwdata[`HCS_FC_BIT];
  assign stk_clr[`HCS_STK_SCTS] = stat_wr & hwdata[`HCS_SCTS_BIT];
  assign stk_clr[`HCS_STK_UR]   = stat_wr & hwdata[`HCS_UR_BIT];
  assign stk_clr[`HCS_STK_FG]   = stat_wr & hwdata[`HCS_FG_BIT];

  // One sticky flag per event; a set in the clearing cycle wins.
  genvar gi;
  generate
    for (gi = 0; gi < `HCS_STK_NUM; gi = gi + 1) begin : g_stk
      hcs_sticky u_stk (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (stk_set[gi]),
        .clr     (stk_clr[gi]),
        .q       (stk_q[gi])
      );
    end
  endgenerate

  // The status word as software sees it; bits above 10 belong to other logic and read zero here.
  always_comb begin
    status_word                            = 32'h0000_0000;
    status_word[`HCS_RB_MSB:`HCS_RB_LSB]   = s.rem_bytes;
    status_word[`HCS_FC_BIT]               = stk_q[`HCS_STK_FC];
    status_word[`HCS_TX_FIFO_AVAILABLE_BIT]             = s.tx_fa;
    status_word[`HCS_CTS_BIT]              = ~s.cts_prev;
    status_word[`HCS_SCTS_BIT]             = stk_q[`HCS_STK_SCTS];
    status_word[`HCS_UR_BIT]               = stk_q[`HCS_STK_UR];
    status_word[`HCS_RX_FIFO_AVAILABLE_BIT]             = s.rx_fa;
    status_word[`HCS_FG_BIT]               = stk_q[`HCS_STK_FG];
  end

  // Next-state logic for the bus slave and the level bits.
  always_comb begin
    next_s           = s;
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    next_s.abort_req = ur_evt;
    next_s.cts_prev  = cts_sync;

    // Address phase: remember writes, answer reads in the following data phase.
    next_s.wr_pend = take & hwrite;
    next_s.wr_addr = haddr[`HCS_ADDR_W-1:0];
    next_s.hrdata  = 32'h0000_0000;
    if (take && !hwrite) begin
      if (hcs_hit(haddr[`HCS_ADDR_W-1:0], `HCS_STATUS_OFF)) begin
        next_s.hrdata = status_word;
      end else if (hcs_hit(haddr[`HCS_ADDR_W-1:0], `HCS_CONFIG_OFF)) begin
        next_s.hrdata = {{(32-`HCS_CFG_W){1'b0}}, s.cfg};
      end
    end

    // Data phase: only the configuration word stores data; the status word takes clears.
    if (s.wr_pend && hcs_hit(s.wr_addr, `HCS_CONFIG_OFF)) begin
      next_s.cfg = hwdata[`HCS_CFG_W-1:0];
    end

    // Transmit space follows the FIFO and is masked while DMA owns the transmitter.
    if (dma_tx) begin
      next_s.tx_fa = 1'b0;
    end else if (four) begin
      next_s.tx_fa = tx_ev.first4_empty;
    end else begin
      next_s.tx_fa = tx_ev.first_empty;
    end

    // The FIFO reports only payload words, so address and final words never show here.
    if (dma_rx) begin
      next_s.rx_fa = 1'b0;
    end else if (four) begin
      next_s.rx_fa = rx_ev.last4_has_data | rx_ev.last_eof_two;
    end else begin
      next_s.rx_fa = rx_ev.last_has_data;
    end

    // The final byte count is held until the next complete frame replaces it.
    if (rx_ev.frame_done) begin
      next_s.rem_bytes = hcs_rb(rx_ev.final_bytes, four);
    end
  end

  // Bus, configuration and level state in one register; reset leaves the slave ready and idle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s           <= '0;
      s.hreadyout <= 1'b1;
      s.cfg       <= `HCS_CFG_RST;
      s.rem_bytes <= `HCS_RB_RST;
      s.cts_prev  <= `HCS_CTS_N_RST;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes from the state register.
  assign hreadyout    = s.hreadyout;
  assign hresp        = s.hresp;
  assign hrdata       = s.hrdata;
  assign tx_abort_req = s.abort_req;

  // Size is not checked: only whole-word transfers reach this slave.
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:`HCS_ADDR_W], htrans[0], hwdata[31:11]};

  // The sticky checks look one edge after the event, before any later write can clear the flag.
  rb_one_range_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_ev.frame_done && !four) |=> s.rem_bytes <= `HCS_RB_MAX_ONE)
    else $error("Remaining bytes out of range in one-word mode.");

  rb_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_ev.frame_done && four && rx_ev.final_bytes != 5'h00 && rx_ev.final_bytes <= 5'h10)
    |=> s.rem_bytes == 4'($past(rx_ev.final_bytes) - 5'h01))
    else $error("Remaining bytes not final count minus one.");

  frame_complete_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_ev.fifo_empty && (tx_ev.abort_sent || tx_ev.flag_sent)) |=> status_word[`HCS_FC_BIT])
    else $error("Frame complete flag not set.");

  tx_fifo_available_dma_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    dma_tx |=> !status_word[`HCS_TX_FIFO_AVAILABLE_BIT])
    else $error("Transmit space shown during transmit DMA.");

  tx_fifo_available_four_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_tx && four && !tx_ev.first4_empty) |=> !s.tx_fa)
    else $error("Transmit space shown with four-word block busy.");

  cts_mirror_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!clear_to_send_in_n) [*4] |=> status_word[`HCS_CTS_BIT])
    else $error("Clear-to-send mirror wrong for low pin.");

  cts_change_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(s.cts_prev) |-> status_word[`HCS_SCTS_BIT])
    else $error("Clear-to-send change not stored.");

  abort_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    ur_evt |=> tx_abort_req && status_word[`HCS_UR_BIT])
    else $error("Underrun did not request an abort.");

  rx_fifo_available_dma_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    dma_rx |=> !status_word[`HCS_RX_FIFO_AVAILABLE_BIT])
    else $error("Receive data shown during receive DMA.");

  frame_good_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_ev.frame_ok |=> status_word[`HCS_FG_BIT])
    else $error("Frame good flag not set.");

  read_no_effect_a: assert property (@(posedge ref_clk) disable iff (rst)
    (take && !hwrite && !s.wr_pend) |=> s.cfg == $past(s.cfg))
    else $error("A read changed stored state.");

  // Byte count: clamped, zero for an empty unit, and held between frames.
  rb_clamp_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_ev.frame_done && !four && rx_ev.final_bytes > 5'h04)
    |=> s.rem_bytes == `HCS_RB_MAX_ONE)
    else $error("Oversized count not clamped.");

  rb_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_ev.frame_done && rx_ev.final_bytes == 5'h00)
    |=> s.rem_bytes == 4'h0)
    else $error("Empty final unit not read as zero.");

  rb_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !rx_ev.frame_done
    |=> s.rem_bytes == $past(s.rem_bytes))
    else $error("Remaining bytes changed between frames.");

  // A written one clears a flag unless its event lands in the same cycle.
  fc_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stat_wr && hwdata[`HCS_FC_BIT] && !stk_set[`HCS_STK_FC])
    |=> !stk_q[`HCS_STK_FC])
    else $error("Frame complete flag not cleared.");

  scts_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stat_wr && hwdata[`HCS_SCTS_BIT] && !stk_set[`HCS_STK_SCTS])
    |=> !stk_q[`HCS_STK_SCTS])
    else $error("Stored clear-to-send not cleared.");

  ur_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stat_wr && hwdata[`HCS_UR_BIT] && !stk_set[`HCS_STK_UR])
    |=> !stk_q[`HCS_STK_UR])
    else $error("Underrun flag not cleared.");

  fg_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stat_wr && hwdata[`HCS_FG_BIT] && !stk_set[`HCS_STK_FG])
    |=> !stk_q[`HCS_STK_FG])
    else $error("Frame good flag not cleared.");

  zero_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (stat_wr && !hwdata[`HCS_FC_BIT] && stk_q[`HCS_STK_FC])
    |=> stk_q[`HCS_STK_FC])
    else $error("Writing zero cleared a flag.");

  // Pin mirror and abort request.
  cts_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    clear_to_send_in_n [*4]
    |=> !status_word[`HCS_CTS_BIT])
    else $error("Clear-to-send mirror wrong for high pin.");

  abort_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    !ur_evt
    |=> !tx_abort_req)
    else $error("Abort requested without underrun.");

  // Availability bits follow their FIFO condition one edge later.
  tx_fifo_available_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_tx && !four)
    |=> s.tx_fa == $past(tx_ev.first_empty))
    else $error("One-word transmit space wrong.");

  tx_fifo_available_open_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_tx && four && tx_ev.first4_empty)
    |=> s.tx_fa)
    else $error("Four-word transmit space not shown.");

  rx_fifo_available_one_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_rx && !four)
    |=> s.rx_fa == $past(rx_ev.last_has_data))
    else $error("One-word receive data flag wrong.");

  rx_fifo_available_four_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_rx && four && rx_ev.last4_has_data)
    |=> s.rx_fa)
    else $error("Four-word receive data not shown.");

  rx_fifo_available_eof_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_rx && four && rx_ev.last_eof_two)
    |=> s.rx_fa)
    else $error("Two words with end marker not shown.");

  rx_fifo_available_empty_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dma_rx && four && !rx_ev.last4_has_data && !rx_ev.last_eof_two)
    |=> !s.rx_fa)
    else $error("Receive data shown with none present.");

  // Reads return the status word and leave every flag alone.
  read_data_a: assert property (@(posedge ref_clk) disable iff (rst)
    (take && !hwrite && hcs_hit(haddr[`HCS_ADDR_W-1:0], `HCS_STATUS_OFF))
    |=> hrdata == $past(status_word))
    else $error("Status read returned wrong data.");

  read_keeps_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
    (take && !hwrite && !s.wr_pend && stk_set == '0)
    |=> stk_q == $past(stk_q))
    else $error("A read changed a flag.");

endmodule

// [hcs_map.svh]
// Register offsets, field positions and reset values of the channel status block.
`ifndef HCS_MAP_SVH
`define HCS_MAP_SVH

// Byte offsets, decoded on the low address byte.
`define HCS_ADDR_W       8
`define HCS_STATUS_OFF   8'h00
`define HCS_CONFIG_OFF   8'h04

// Status word field positions.
`define HCS_RB_MSB       3
`define HCS_RB_LSB       0
`define HCS_FC_BIT       4
`define HCS_TX_FIFO_AVAILABLE_BIT     5
`define HCS_CTS_BIT      6
`define HCS_SCTS_BIT     7
`define HCS_UR_BIT       8
`define HCS_RX_FIFO_AVAILABLE_BIT     9
`define HCS_FG_BIT       10

// Configuration word field positions.
`define HCS_CFG_W        3
`define HCS_CFG_FOUR_BIT 0
`define HCS_CFG_DTX_BIT  1
`define HCS_CFG_DRX_BIT  2

// Reset values and field limits.
`define HCS_CFG_RST      3'h0
`define HCS_RB_RST       4'h0
`define HCS_CTS_N_RST    1'b1
`define HCS_RB_MAX_ONE   4'h3
`define HCS_RB_MAX_FOUR  4'hf

// Positions of the write-one-to-clear bits in the sticky vector.
`define HCS_STK_FC       0
`define HCS_STK_SCTS     1
`define HCS_STK_UR       2
`define HCS_STK_FG       3
`define HCS_STK_NUM      4

`endif

// [hcs_pkg.sv]
// Types shared by the channel status block and its helper modules.
`include "hcs_map.svh"

package hcs_pkg;

  // Events and levels from the transmitter and the transmit FIFO.
  typedef struct packed {
    logic fifo_empty;
    logic first_empty;
    logic first4_empty;
    logic abort_sent;
    logic flag_sent;
    logic frame_ok;
    logic need_data;
    logic in_frame;
  } hcs_tx_ev_t;

  // Events and levels from the receiver and the receive FIFO.
  typedef struct packed {
    logic       last_has_data;
    logic       last4_has_data;
    logic       last_eof_two;
    logic       frame_done;
    logic [4:0] final_bytes;
  } hcs_rx_ev_t;

  // State of the status block apart from its sticky flags and synchroniser.
  typedef struct packed {
    logic                     wr_pend;
    logic [`HCS_ADDR_W-1:0]   wr_addr;
    logic                     hreadyout;
    logic                     hresp;
    logic [31:0]              hrdata;
    logic [`HCS_CFG_W-1:0]    cfg;
    logic [3:0]               rem_bytes;
    logic                     tx_fa;
    logic                     rx_fa;
    logic                     cts_prev;
    logic                     abort_req;
  } hcs_top_state_t;

  // State of the two-stage synchroniser.
  typedef struct packed {
    logic stage1;
    logic stage2;
  } hcs_sync_state_t;

  // State of one sticky flag.
  typedef struct packed {
    logic q;
  } hcs_stk_state_t;

endpackage

// [hcs_sync.sv]
// Two flip-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
`include "hcs_map.svh"

module hcs_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  import hcs_pkg::*;

  hcs_sync_state_t s;
  hcs_sync_state_t next_s;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_comb begin
    next_s        = s;
    next_s.stage1 = d;
    next_s.stage2 = s.stage1;
  end

  // Both stages reset to the idle (high) pin level.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= {`HCS_CTS_N_RST, `HCS_CTS_N_RST};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stage2;

endmodule

// [hcs_sticky.sv]
// One write-one-to-clear status flag in which a set beats a clear.
`timescale 1ns/1ps

module hcs_sticky (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  import hcs_pkg::*;

  hcs_stk_state_t s;
  hcs_stk_state_t next_s;

  // An event in the clearing cycle survives, so no event is ever lost.
  always_comb begin
    next_s   = s;
    next_s.q = set | (s.q & ~clr);
  end

  // The flag starts cleared.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;

  set_wins_a: assert property (@(posedge ref_clk) disable iff (rst) set |=> q)
    else $error("Sticky flag lost a set event.");

  hold_flag_a: assert property (@(posedge ref_clk) disable iff (rst) (!set && !clr) |=> q == $past(q))
    else $error("Sticky flag changed without set or clear.");

endmodule

// [hcs_peer.sv]
// Far-side model: transmitter, receiver, FIFO levels and the clear-to-send pin.
`timescale 1ns/1ps

module hcs_peer (
  input  wire logic          ref_clk,
  input  wire logic          tx_abort_req,
  output hcs_pkg::hcs_tx_ev_t tx_ev,
  output hcs_pkg::hcs_rx_ev_t rx_ev,
  output logic               cts_n
);
  import hcs_pkg::*;

  int aborts;

  // Everything idles quiet, and the pin starts high, as a modem that is not ready.
  initial begin
    tx_ev  = '0;
    rx_ev  = '0;
    cts_n  = 1'b1;
    aborts = 0;
  end

  // The transmitter obeys an abort request one cycle later and counts it.
  always @(posedge ref_clk) begin
    tx_ev.abort_sent <= tx_abort_req;
    if (tx_abort_req === 1'b1) begin
      aborts <= aborts + 1;
    end
  end

  // Level conditions of the transmit side.
  task automatic set_tx(input logic fe, fst, fst4, inf);
    @(posedge ref_clk);
    tx_ev.fifo_empty   <= fe;
    tx_ev.first_empty  <= fst;
    tx_ev.first4_empty <= fst4;
    tx_ev.in_frame     <= inf;
  endtask

  // One-cycle transmit events: m[2] closing flag, m[1] good frame, m[0] data wanted.
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    {tx_ev.flag_sent, tx_ev.frame_ok, tx_ev.need_data} <= m;
    @(posedge ref_clk);
    {tx_ev.flag_sent, tx_ev.frame_ok, tx_ev.need_data} <= 3'h0;
  endtask

  // Level conditions of the receive FIFO.
  task automatic set_rx(input logic l1, l4, eof2);
    @(posedge ref_clk);
    rx_ev.last_has_data  <= l1;
    rx_ev.last4_has_data <= l4;
    rx_ev.last_eof_two   <= eof2;
  endtask

  // End of a received frame; the byte count is garbage once the strobe drops.
  task automatic done(input logic [4:0] b);
    @(posedge ref_clk);
    rx_ev.frame_done  <= 1'b1;
    rx_ev.final_bytes <= b;
    @(posedge ref_clk);
    rx_ev.frame_done  <= 1'b0;
    rx_ev.final_bytes <= ~b;
  endtask

  // The pin changes only on a clock edge, like any synchronous stimulus here.
  task automatic cts(input logic v);
    @(posedge ref_clk);
    cts_n <= v;
  endtask
endmodule

// [test_hcs_status.sv]
// Self-checking testbench of the channel status block.
`timescale 1ns/1ps
`include "hcs_map.svh"

module test_hcs_status;
  import hcs_pkg::*;

  logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp, tx_abort_req, cts_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  hcs_tx_ev_t  tx_ev;
  hcs_rx_ev_t  rx_ev;
  int          failures, cmp_count;

  localparam logic [31:0] a_st = {24'h0, `HCS_STATUS_OFF};
  localparam logic [31:0] a_cf = {24'h0, `HCS_CONFIG_OFF};
  localparam logic [31:0] m_fc = 32'h1 << `HCS_FC_BIT;
  localparam logic [31:0] m_tf = 32'h1 << `HCS_TX_FIFO_AVAILABLE_BIT;
  localparam logic [31:0] m_ct = 32'h1 << `HCS_CTS_BIT;
  localparam logic [31:0] m_sc = 32'h1 << `HCS_SCTS_BIT;
  localparam logic [31:0] m_ur = 32'h1 << `HCS_UR_BIT;
  localparam logic [31:0] m_rf = 32'h1 << `HCS_RX_FIFO_AVAILABLE_BIT;
  localparam logic [31:0] m_fg = 32'h1 << `HCS_FG_BIT;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  hcs_status u_hcs_status (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .tx_ev(tx_ev), .rx_ev(rx_ev), .clear_to_send_in_n(cts_n),
    .tx_abort_req(tx_abort_req));

  hcs_peer u_hcs_peer (.ref_clk(ref_clk), .tx_abort_req(tx_abort_req), .tx_ev(tx_ev), .rx_ev(rx_ev),
    .cts_n(cts_n));

  // Clock at 100 MHz.
  always #5 ref_clk = ~ref_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer; waits on ready rather than assuming zero wait states.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hsize  <= 3'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic st(input string nm, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a_st, 32'h0, r);
    chk(nm, r, e);
  endtask

  // Long enough for the deepest path, the three-stage pin latency.
  task automatic idle(input int n = 5);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    logic [31:0] r;
    st("status reset", 32'h0);
    ahb(1'b0, a_cf, 32'h0, r);
    chk("config reset", r, 32'h0);
    ahb(1'b0, 32'h10, 32'h0, r);
    chk("unmapped read", r, 32'h0);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask

  task automatic t_tx_space;
    u_hcs_peer.set_tx(1'b0, 1'b1, 1'b0, 1'b0);
    idle(); st("tx_fifo_available one-word", m_tf);
    wr(a_cf, 32'h1); idle(); st("tx_fifo_available four partial", 32'h0);
    u_hcs_peer.set_tx(1'b0, 1'b1, 1'b1, 1'b0);
    idle(); st("tx_fifo_available four-word", m_tf);
    wr(a_st, 32'hffffffff); st("tx_fifo_available after write", m_tf);
    wr(a_cf, 32'h3); idle(); st("tx_fifo_available dma", 32'h0);
    wr(a_cf, 32'h1); u_hcs_peer.set_tx(1'b0, 1'b0, 1'b0, 1'b0);
    idle(); st("tx_fifo_available gone", 32'h0);
  endtask

  task automatic t_rx_avail;
    wr(a_cf, 32'h0); u_hcs_peer.set_rx(1'b1, 1'b0, 1'b0);
    idle(); st("rx_fifo_available one-word", m_rf);
    wr(a_cf, 32'h1); idle(); st("rx_fifo_available four partial", 32'h0);
    u_hcs_peer.set_rx(1'b1, 1'b0, 1'b1);
    idle(); st("rx_fifo_available two words end", m_rf);
    u_hcs_peer.set_rx(1'b1, 1'b1, 1'b0);
    idle(); st("rx_fifo_available four-word", m_rf);
    wr(a_cf, 32'h5); idle(); st("rx_fifo_available dma", 32'h0);
    wr(a_cf, 32'h1); u_hcs_peer.set_rx(1'b0, 1'b0, 1'b0);
    idle(); st("rx_fifo_available gone", 32'h0);
  endtask

  // Every count of the one-word unit, then both ends of the four-word range.
  task automatic t_remaining;
    wr(a_cf, 32'h0);
    for (int b = 1; b <= 4; b++) begin
      u_hcs_peer.done(5'(b));
      idle(); st("remaining one-word", 32'(b - 1));
    end
    wr(a_cf, 32'h1); u_hcs_peer.done(5'd16);
    idle(); st("remaining four max", 32'hf);
    wr(a_st, 32'hffffffff); st("remaining after write", 32'hf);
    u_hcs_peer.done(5'd1);
    idle(); st("remaining four min", 32'h0);
    wr(a_cf, 32'h0);
  endtask

  task automatic t_cts;
    logic [31:0] r;
    u_hcs_peer.cts(1'b0);
    idle(); st("cts low", m_ct | m_sc);
    ahb(1'b0, 32'h100 | a_st, 32'h0, r);
    chk("cts alias", r, m_ct | m_sc);
    st("cts reread", m_ct | m_sc);
    wr(a_st, ~m_sc); st("cts write zero", m_ct | m_sc);
    wr(a_st, m_sc); st("cts cleared", m_ct);
    u_hcs_peer.cts(1'b1);
    idle(); st("cts high", m_sc);
    wr(a_st, m_sc); st("cts clear again", 32'h0);
  endtask

  task automatic t_tx_events;
    u_hcs_peer.set_tx(1'b1, 1'b0, 1'b0, 1'b1);
    u_hcs_peer.pulse(3'h1);
    idle(); chk("abort requests", 32'(u_hcs_peer.aborts), 32'h1);
    st("underrun", m_ur | m_fc);
    wr(a_st, m_ur); st("underrun cleared", m_fc);
    wr(a_st, m_fc); st("complete cleared", 32'h0);
    u_hcs_peer.set_tx(1'b0, 1'b0, 1'b0, 1'b0);
    u_hcs_peer.pulse(3'h4);
    idle(); st("flag with data left", 32'h0);
    u_hcs_peer.set_tx(1'b1, 1'b0, 1'b0, 1'b0);
    u_hcs_peer.pulse(3'h7);
    idle(); st("frame good", m_fc | m_fg);
    chk("no abort outside frame", 32'(u_hcs_peer.aborts), 32'h1);
    wr(a_st, m_fc | m_fg); st("good cleared", 32'h0);
  endtask

  // A reset in mid-run must clear a set flag and the configuration.
  task automatic t_mid_reset;
    logic [31:0] r;
    wr(a_cf, 32'h7);
    u_hcs_peer.pulse(3'h2);
    idle(); st("good before reset", m_fg);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("ready in reset", {31'h0, hreadyout}, 32'h1);
    chk("abort in reset", {31'h0, tx_abort_req}, 32'h0);
    rst <= 1'b0;
    st("status after reset", 32'h0);
    ahb(1'b0, a_cf, 32'h0, r);
    chk("config after reset", r, 32'h0);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence; inputs settle at time zero, reset is held for 20 cycles.
  initial begin
    ref_clk   = 1'b0;
    rst       = 1'b1;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h0;
    hwdata    = 32'h0;
    failures  = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_tx_space();
    t_rx_avail();
    t_remaining();
    t_cts();
    t_tx_events();
    t_mid_reset();
    stop_test();
  end

  // The whole run needs well under a thousand cycles; a hang ends here.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test();
  end
endmodule
